// File: shared/wdt_params.svh
// Purpose: constants of the watchdog timer
// Assumes: one watchdog clock equals one enabled core_clk cycle
// Notes: definitions only
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH
`define WDT_CNT_W 18
`define WDT_SEL_W 3
`define WDT_BASE_EXP 5'h04
`define WDT_EXP_STEP 2
`define WDT_GRACE_CYCLES 1024
`define WDT_GRACE_W 10
`define WDT_HOLD_CYCLES 63
`define WDT_HOLD_W 6
`define WDT_RESET_VECTOR 32'h0000_0000
`endif

// File: shared/wdt_pkg.sv
// Purpose: types of the watchdog timer
// Assumes: control word laid out as the control register, MSB first
// Notes: bit 6 holds the interrupt enable
package wdt_pkg;
    typedef enum {PH_RUN, PH_GRACE, PH_HOLD} wdt_phase_type;
    typedef struct packed {
        logic [2:0] intervalSelect;   // 10:8
        logic wdogEnable;             // 7
        logic timeoutIrqEnable;       // 6
        logic spare5;                 // 5
        logic wakeupEnable;           // 4
        logic [1:0] spare3;           // 3:2
        logic wdogResetEnable;        // 1
        logic counterRestart;         // 0, one-cycle write of one
    } wdt_control_type;
    typedef struct packed {
        logic timeoutIrqFlag;
        logic irqRequest;
        logic wdogResetFlag;
        logic counterRestart;
        logic chipReset;
        logic wakeup;
    } wdt_status_type;
endpackage : wdt_pkg

// File: hw/wdt_watchdog_timer.sv
// Purpose: watchdog timer with time-out flag, grace delay, chip reset and wake-up
// Assumes: core_clk is the watchdog clock; control bits are plain inputs
// Notes: resetn is the power-on reset only, so the reset flag survives chipReset
//
// Behaviour
// - enable bit starts counter on each clock
// - eighteen bit free running up counter
// - interval hit sets flag; request needs enable
// - no restart within 1024 clocks resets chip
// - restart bit clears counter, self clears
// - interval select picks 2^4 to 2^18
// - chip reset held 63 clocks, vector zero
// - reset flag survives watchdog caused reset
// - interval hit in power down wakes chip
`timescale 1ns/1ps
`include "wdt_params.svh"

module wdt_watchdog_timer #(
    parameter int CNT_W = `WDT_CNT_W,
    parameter int GRACE_CYCLES = `WDT_GRACE_CYCLES,
    parameter int HOLD_CYCLES = `WDT_HOLD_CYCLES
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire wdt_pkg::wdt_control_type control,
    input wire logic powerDown,
    input wire logic timeoutIrqFlagClear,
    input wire logic wdogResetFlagClear,
    output wdt_pkg::wdt_status_type status,
    output logic [CNT_W-1:0] counterValue
);
    import wdt_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        wdt_phase_type phase;
        logic [CNT_W-1:0] count;
        logic [`WDT_GRACE_W-1:0] grace;
        logic [`WDT_HOLD_W-1:0] hold;
        wdt_status_type st;
    } wdt_state_type;

    wdt_state_type state;
    wdt_state_type next_state;
    logic [4:0] intervalExp;
    logic [CNT_W:0] intervalLen;
    logic [CNT_W:0] countPlusOne;
    logic intervalHit;
    logic [CNT_W-1:0] chipResetVector;

    assign chipResetVector = CNT_W'(`WDT_RESET_VECTOR);

    // ----------------------------------------------------------------
    // Interval decode
    // ----------------------------------------------------------------
    always_comb begin
        intervalExp = `WDT_BASE_EXP + 5'(control.intervalSelect * `WDT_EXP_STEP);
        intervalLen = (CNT_W+1)'(1) << intervalExp;
        countPlusOne = {1'b0, state.count} + (CNT_W+1)'(1);
        // Compare one bit wider so the 2^18 interval is seen as the wrap
        intervalHit = control.wdogEnable && !state.st.counterRestart
            && state.phase != PH_HOLD && countPlusOne == intervalLen;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.st.wakeup = 1'b0;
        if (state.st.counterRestart) begin
            // Clear takes one cycle; the bit reads one until it has acted
            next_state.count = '0;
            next_state.st.counterRestart = 1'b0;
            if (state.phase == PH_GRACE) begin
                next_state.phase = PH_RUN;
            end
        end else if (control.wdogEnable && state.phase != PH_HOLD) begin
            next_state.count = countPlusOne[CNT_W-1:0];
        end
        if (control.counterRestart) begin
            next_state.st.counterRestart = 1'b1;
        end
        if (timeoutIrqFlagClear) begin
            next_state.st.timeoutIrqFlag = 1'b0;
        end
        if (wdogResetFlagClear) begin
            next_state.st.wdogResetFlag = 1'b0;
        end
        if (intervalHit) begin
            // Set after clear so a hit in the clearing cycle is kept
            next_state.st.timeoutIrqFlag = 1'b1;
            next_state.st.wakeup = powerDown && control.wakeupEnable;
        end
        case (state.phase)
            PH_RUN: begin
                if (intervalHit) begin
                    next_state.phase = PH_GRACE;
                    next_state.grace = '0;
                end
            end
            PH_GRACE: begin
                if (!control.wdogEnable) begin
                    next_state.phase = PH_RUN;
                end else if (!state.st.counterRestart) begin
                    next_state.grace = state.grace + 1'b1;
                    if (32'(state.grace) == GRACE_CYCLES - 1) begin
                        // Without reset enable the time-out only flags
                        if (control.wdogResetEnable) begin
                            next_state.phase = PH_HOLD;
                            next_state.hold = '0;
                            next_state.st.wdogResetFlag = 1'b1;
                            next_state.st.chipReset = 1'b1;
                            next_state.count = chipResetVector;
                            // A restart in the expiry cycle is too late and is dropped
                            next_state.st.counterRestart = 1'b0;
                        end else begin
                            next_state.phase = PH_RUN;
                        end
                    end
                end
            end
            PH_HOLD: begin
                // Counting stops for the hold; a restart here only re-zeroes
                next_state.count = '0;
                next_state.hold = state.hold + 1'b1;
                if (32'(state.hold) == HOLD_CYCLES - 1) begin
                    next_state.phase = PH_RUN;
                    next_state.st.chipReset = 1'b0;
                end
            end
            default: begin
                next_state.phase = PH_RUN;
            end
        endcase
        next_state.st.irqRequest = next_state.st.timeoutIrqFlag
            && control.timeoutIrqEnable;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= '{phase: PH_RUN, count: '0, grace: '0, hold: '0, st: '0};
        end else if (clkEn) begin
            state <= next_state;
        end
    end

    assign status = state.st;
    assign counterValue = state.count;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_restart_clears: assert property (@(posedge core_clk) disable iff (!resetn)
        clkEn && state.st.counterRestart && !control.counterRestart && state.phase != PH_HOLD
        |=> counterValue == '0 && !status.counterRestart)
        else $error("restart did not clear counter");
    chk_count_up: assert property (@(posedge core_clk) disable iff (!resetn)
        clkEn && control.wdogEnable && !state.st.counterRestart && state.phase != PH_HOLD
        && next_state.phase != PH_HOLD
        |=> counterValue == $past(counterValue) + 1'b1)
        else $error("counter did not advance");
    chk_count_frozen: assert property (@(posedge core_clk) disable iff (!resetn)
        !control.wdogEnable && !state.st.counterRestart |=> $stable(counterValue))
        else $error("disabled counter moved");
    chk_flag_on_hit: assert property (@(posedge core_clk) disable iff (!resetn)
        clkEn && intervalHit |=> status.timeoutIrqFlag)
        else $error("time-out flag not set");
    chk_irq_gate: assert property (@(posedge core_clk) disable iff (!resetn)
        status.irqRequest |-> status.timeoutIrqFlag)
        else $error("request without flag");
    chk_sel_zero_hit: assert property (@(posedge core_clk) disable iff (!resetn)
        clkEn && control.intervalSelect == 3'h0 && control.wdogEnable
        && !state.st.counterRestart && state.phase != PH_HOLD
        && counterValue == CNT_W'((1 << `WDT_BASE_EXP) - 1)
        |-> intervalHit)
        else $error("interval 2^4 missed");
    chk_reset_hold: assert property (@(posedge core_clk) disable iff (!resetn)
        $fell(status.chipReset) |-> 32'($past(state.hold)) == HOLD_CYCLES - 1)
        else $error("chip reset length wrong");
    chk_reset_flag: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(status.chipReset) |-> status.wdogResetFlag)
        else $error("reset without flag");
    chk_reset_enable: assert property (@(posedge core_clk) disable iff (!resetn)
        state.phase == PH_GRACE && !control.wdogResetEnable |=> !$rose(status.chipReset))
        else $error("reset while disabled");
    chk_wake: assert property (@(posedge core_clk) disable iff (!resetn)
        clkEn && intervalHit && powerDown && control.wakeupEnable |=> status.wakeup)
        else $error("no wake-up");
    chk_grace_len: assert property (@(posedge core_clk) disable iff (!resetn)
        state.phase == PH_GRACE && 32'(state.grace) == GRACE_CYCLES - 1 && clkEn
        && control.wdogEnable && control.wdogResetEnable && !state.st.counterRestart
        |=> status.chipReset && state.phase == PH_HOLD)
        else $error("grace expiry missed");

    // ----------------------------------------------------------------
    // Checks of hold, latches, sticky flags and wake-up pulse
    // ----------------------------------------------------------------
    chk_hold_stands: assert property (@(posedge core_clk) disable iff (!resetn)
        state.phase == PH_HOLD |-> status.chipReset && counterValue == '0)
        else $error("hold phase without chip reset");
    chk_restart_latch: assert property (@(posedge core_clk) disable iff (!resetn)
        clkEn && control.counterRestart && !(state.phase == PH_GRACE && next_state.phase == PH_HOLD)
        |=> status.counterRestart)
        else $error("restart request lost");
    chk_irq_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
        status.timeoutIrqFlag && !timeoutIrqFlagClear |=> status.timeoutIrqFlag)
        else $error("time-out flag lost");
    chk_rflag_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
        status.wdogResetFlag && !wdogResetFlagClear |=> status.wdogResetFlag)
        else $error("reset flag lost");
    chk_wake_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
        clkEn && status.wakeup && !intervalHit |=> !status.wakeup)
        else $error("wake-up pulse too long");
endmodule : wdt_watchdog_timer

// File: tb/tb.sv
// Purpose: self-checking bench for the watchdog timer
// Assumes: grace and hold shortened by parameters
// Notes: drives on the rising edge, samples on the falling edge
`timescale 1ns/1ps
module tb;
    import wdt_pkg::*;
    localparam int GR = 8;
    localparam int HD = 4;
    logic core_clk = 0;
    logic resetn = 0;
    logic clkEn = 1;
    wdt_control_type ctl = '0;
    logic powerDown = 0;
    logic irqClr = 0;
    logic rstClr = 0;
    wdt_status_type st;
    logic [17:0] cnt;
    int err_total = 0;
    int samples_checked = 0;
    int seed = 63709;
    int n;
    logic [31:0] ival;
    logic [31:0] rnd;
    wdt_watchdog_timer #(.GRACE_CYCLES(GR), .HOLD_CYCLES(HD)) u_dut (.core_clk(core_clk),
        .resetn(resetn), .clkEn(clkEn), .control(ctl), .powerDown(powerDown),
        .timeoutIrqFlagClear(irqClr), .wdogResetFlagClear(rstClr), .status(st),
        .counterValue(cnt));
    initial forever #10 core_clk = ~core_clk;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk_val(string nm, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk_val
    task automatic cyc(int k);
        repeat (k) @(negedge core_clk);
    endtask : cyc
    // Bounded poll; a missing event shows up as a mismatch
    task automatic wait_bit(int i, int lim, output int k);
        k = 0;
        while (st[i] !== 1'b1 && k < lim) begin
            cyc(1);
            k++;
        end
        chk_val("event", 1, {31'h0, st[i]});
    endtask : wait_bit
    task automatic restart();
        @(posedge core_clk) ctl.counterRestart <= 1'b1;
        @(posedge core_clk) ctl.counterRestart <= 1'b0;
        cyc(3);
    endtask : restart
    task automatic quiet();
        @(posedge core_clk) begin
            ctl.wdogEnable <= 1'b0;
            irqClr <= 1'b1;
            rstClr <= 1'b1;
        end
        @(posedge core_clk) begin
            irqClr <= 1'b0;
            rstClr <= 1'b0;
        end
        restart();
    endtask : quiet
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        cyc(1);
        chk_val("count", 0, {14'h0, cnt});
        // Select codes 0..3 only: larger ones add nothing but run time
        for (int s = 0; s < 4; s++) begin
            rnd = $random(seed);
            @(posedge core_clk) begin
                ctl.intervalSelect <= s[2:0];
                ctl.timeoutIrqEnable <= rnd[0];
                ctl.spare5 <= rnd[1];
                ctl.wdogEnable <= 1'b1;
            end
            wait_bit(5, 2000, n);
            ival = 32'h1 << (4 + 2 * s);
            chk_val("interval", ival, {14'h0, cnt});
            chk_val("irq", {31'h0, rnd[0]}, {31'h0, st.irqRequest});
            chk_val("nowake", 0, {31'h0, st.wakeup});
            cyc(GR + HD + 4);
            chk_val("noreset", 0, {30'h0, st.chipReset, st.wdogResetFlag});
            chk_val("running", ival + GR + HD + 4, {14'h0, cnt});
            quiet();
            chk_val("cleared", 0, {13'h0, cnt, st.counterRestart});
            chk_val("flagclr", 0, {31'h0, st.timeoutIrqFlag});
        end
        @(posedge core_clk) begin
            ctl.intervalSelect <= 3'h0;
            ctl.wdogResetEnable <= 1'b1;
            ctl.wdogEnable <= 1'b1;
        end
        wait_bit(5, 100, n);
        wait_bit(1, 2 * GR, n);
        chk_val("grace", GR, n);
        chk_val("rstflag", 1, {31'h0, st.wdogResetFlag});
        n = 0;
        while (st.chipReset === 1'b1 && n < 100) begin
            chk_val("hold", 0, {14'h0, cnt});
            cyc(1);
            n++;
        end
        chk_val("holdlen", HD, n);
        chk_val("survive", 1, {31'h0, st.wdogResetFlag});
        quiet();
        @(posedge core_clk) ctl.wdogEnable <= 1'b1;
        wait_bit(5, 100, n);
        cyc(GR / 2);
        restart();
        // Freeze after the restart has cancelled the grace run
        @(posedge core_clk) clkEn <= 1'b0;
        cyc(2);
        ival = {14'h0, cnt};
        cyc(5);
        chk_val("freeze", ival, {14'h0, cnt});
        @(posedge core_clk) clkEn <= 1'b1;
        cyc(GR);
        chk_val("nogrst", 0, {31'h0, st.wdogResetFlag});
        chk_val("small", 1, {31'h0, cnt < 18'h10});
        quiet();
        @(posedge core_clk) begin
            ctl.wdogResetEnable <= 1'b0;
            ctl.wakeupEnable <= 1'b1;
            ctl.intervalSelect <= 3'h1;
            powerDown <= 1'b1;
            ctl.wdogEnable <= 1'b1;
        end
        wait_bit(0, 200, n);
        chk_val("wake", 32'h40, {14'h0, cnt});
        cyc(1);
        chk_val("wakepulse", 0, {31'h0, st.wakeup});
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        stop_test();
    end
endmodule : tb
